//--- hw/async_serial_channel.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module async_serial_channel #(
  parameter bit THIRD_CHANNEL = 1'b0
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  input  wire logic [serial_pkg::ADDR_W-1:0]  addr,
  input  wire logic [serial_pkg::DATA_W-1:0]  wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [serial_pkg::DATA_W-1:0]  rdata,
  input  wire logic                           serial_in_pin,
  input  wire logic                           transfer_clock_pin,
  output logic                                serial_out_pin,
  output logic                                serial_out_oe,
  input  wire logic                           flow_pin_in,
  output logic                                flow_pin_out,
  output logic                                flow_pin_oe,
  output logic                                tx_request,
  output logic                                rx_request
);
  import serial_pkg::*;

  logic [15:0] mode;
  logic [15:0] ctrl;
  logic [7:0]  div_n;
  logic [8:0]  txbuf;
  logic        tbe;
  logic [8:0]  rxbuf;
  logic        rx_full;
  logic        ovr;
  logic        fer;
  logic        per;

  logic [3:0]  dbits;
  logic [8:0]  dmask;
  logic        ext_sel;
  logic        sleep_on;
  logic        data_inv;
  logic        pin_inv;
  logic        tx_en;
  logic        rx_en;
  logic        cts_ok;

  always_comb begin
    unique case (mode[MODE_LEN +: 2])
      LEN_7:   dbits = 4'h7;
      LEN_9:   dbits = 4'h9;
      default: dbits = 4'h8;
    endcase
  end
  assign dmask    = 9'h1ff >> (MAX_BITS - dbits); // see (RULE1)
  assign ext_sel  = mode[MODE_EXT] & ~THIRD_CHANNEL; // see (RULE20)
  assign sleep_on = mode[MODE_SLEEP] & ~THIRD_CHANNEL; // see (RULE17)
  assign data_inv = ctrl[CTRL_DATA_INV] & THIRD_CHANNEL;
  assign pin_inv  = ctrl[CTRL_PIN_INV] & THIRD_CHANNEL;
  assign tx_en    = ctrl[CTRL_TX_EN];
  assign rx_en    = ctrl[CTRL_RX_EN];

  // Register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode  <= MODE_RESET;
      ctrl  <= CTRL_RESET;
      div_n <= DIV_RESET;
      txbuf <= 9'h000;
    end else if (ce && wr) begin
      unique case (addr)
        REG_MODE:  mode  <= wdata;
        REG_CTRL:  ctrl  <= wdata;
        REG_DIV:   div_n <= wdata[7:0]; // see (RULE5)
        REG_TXBUF: txbuf <= wdata[8:0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers; a level counts once the second and third stages agree
  logic [2:0] rx_sync;
  logic [2:0] xclk_sync;
  logic [2:0] cts_sync;
  logic       rx_level;
  logic       xclk_level;
  logic       cts_level;
  logic       ext_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sync   <= 3'h7;
      xclk_sync <= 3'h0;
      cts_sync  <= 3'h7;
    end else if (ce) begin
      rx_sync   <= {rx_sync[1:0], serial_in_pin};
      xclk_sync <= {xclk_sync[1:0], transfer_clock_pin};
      cts_sync  <= {cts_sync[1:0], flow_pin_in};
    end
  end

  assign ext_rise = (xclk_sync[2] == xclk_sync[1]) && xclk_sync[2] && !xclk_level;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_level   <= 1'b1;
      xclk_level <= 1'b0;
      cts_level  <= 1'b1;
    end else if (ce) begin
      if (rx_sync[2] == rx_sync[1])
        rx_level <= rx_sync[2];
      if (xclk_sync[2] == xclk_sync[1])
        xclk_level <= xclk_sync[2];
      if (cts_sync[2] == cts_sync[1])
        cts_level <= cts_sync[2];
    end
  end

  assign cts_ok = ctrl[CTRL_FLOW_DIS] | ctrl[CTRL_RTS_SEL] | ~cts_level; // see (RULE7)

  // Request-to-send drives low while the receiver can take a character
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flow_pin_out <= 1'b1;
    end else if (ce) begin
      flow_pin_out <= ~(rx_en & ~rx_full);
    end
  end
  assign flow_pin_oe = ~ctrl[CTRL_FLOW_DIS] & ctrl[CTRL_RTS_SEL]; // see (RULE21)

  // Clock selection and bit-rate divider producing the 16x tick
  logic [4:0] pre_cnt;
  logic       src_tick;
  logic [7:0] div_cnt;
  logic       os_tick;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pre_cnt <= 5'h00;
    else if (ce)
      pre_cnt <= pre_cnt + 5'h01;
  end

  always_comb begin
    if (ext_sel) begin
      src_tick = ext_rise; // see (RULE6)
    end else begin
      unique case (ctrl[CTRL_CLK_SEL +: 2])
        CLK_F1:  src_tick = 1'b1;
        CLK_F8:  src_tick = (pre_cnt[2:0] == PRE_F8_LAST);
        CLK_F32: src_tick = (pre_cnt == PRE_F32_LAST);
        default: src_tick = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 8'h00;
      os_tick <= 1'b0;
    end else if (ce) begin
      os_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt == 8'h00) begin
          div_cnt <= div_n; // see (RULE4)
          os_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt - 8'h01;
        end
      end
    end
  end

  // Transmitter
  tx_state_t  tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_os;
  logic [3:0] tx_bits;
  logic       tx_par;
  logic       tx_line;
  logic       tx_start;
  logic       tx_bit_end;
  logic       tx_done;
  logic [8:0] tx_wire;

  assign tx_wire    = (txbuf ^ {9{data_inv}}) & dmask; // see (RULE18)
  assign tx_start   = (tx_state == TX_IDLE) && tx_en && !tbe && cts_ok; // see (RULE7)
  assign tx_bit_end = os_tick && (tx_os == OS_LAST);
  assign tx_done    = (tx_state == TX_STOP) && tx_bit_end && (tx_bits == 4'h0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h000;
      tx_os    <= 4'h0;
      tx_bits  <= 4'h0;
      tx_par   <= 1'b0;
    end else if (ce) begin
      if (os_tick)
        tx_os <= tx_os + 4'h1;
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state <= TX_START; // see (RULE2)
            tx_shift <= tx_wire;
            tx_par   <= (^tx_wire) ^ mode[MODE_ODD]; // see (RULE15)
            tx_os    <= 4'h0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state <= TX_DATA;
            tx_bits  <= dbits - 4'h1;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            if (tx_bits != 4'h0) begin
              tx_bits <= tx_bits - 4'h1;
            end else if (mode[MODE_PAR_EN]) begin
              tx_state <= TX_PARITY;
            end else begin
              tx_state <= TX_STOP;
              tx_bits  <= {3'h0, mode[MODE_STOP2]};
            end
          end
        end
        TX_PARITY: begin
          if (tx_bit_end) begin
            tx_state <= TX_STOP;
            tx_bits  <= {3'h0, mode[MODE_STOP2]}; // see (RULE3)
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            if (tx_bits != 4'h0)
              tx_bits <= tx_bits - 4'h1;
            else
              tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // A write in the load cycle wins, so the new character is never lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      tbe <= 1'b1;
    else if (ce) begin
      if (wr && addr == REG_TXBUF)
        tbe <= 1'b0;
      else if (tx_start)
        tbe <= 1'b1;
    end
  end

  always_comb begin
    unique case (tx_state)
      TX_IDLE:   tx_line = 1'b1;
      TX_START:  tx_line = 1'b0;
      TX_DATA:   tx_line = tx_shift[0];
      TX_PARITY: tx_line = tx_par;
      TX_STOP:   tx_line = 1'b1;
      default:   tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      serial_out_pin <= 1'b1;
    else if (ce)
      serial_out_pin <= tx_line ^ pin_inv; // see (RULE19) (RULE23)
  end
  // Open drain only ever pulls low; a high level leaves the pin floating
  assign serial_out_oe = ~(mode[MODE_OPEN_DR] & serial_out_pin); // see (RULE23)

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      tx_request <= 1'b0;
    else if (ce)
      tx_request <= ctrl[CTRL_TX_WHEN] ? tx_done : tx_start; // see (RULE9) (RULE10)
  end

  // Receiver
  rx_state_t  rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_os;
  logic [3:0] rx_bits;
  logic       rx_in;
  logic       rx_sample;
  logic       rx_per;
  logic       rx_fer;
  logic       rx_done;
  logic [8:0] rx_wire;
  logic       rx_msb;
  logic       rx_accept;
  logic       rx_read;

  assign rx_in     = rx_level ^ pin_inv; // see (RULE19)
  assign rx_sample = os_tick && (rx_os == OS_LAST);
  assign rx_wire   = rx_shift >> (MAX_BITS - dbits);
  assign rx_msb    = rx_wire[dbits - 4'h1];
  assign rx_done   = (rx_state == RX_STOP) && rx_sample && (rx_bits == 4'h0);
  assign rx_accept = rx_done && (!sleep_on || rx_msb); // see (RULE22)
  assign rx_read   = rd && (addr == REG_RXBUF);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_os    <= 4'h0;
      rx_bits  <= 4'h0;
      rx_per   <= 1'b0;
      rx_fer   <= 1'b0;
    end else if (ce) begin
      if (os_tick)
        rx_os <= rx_os + 4'h1;
      if (!rx_en) begin
        rx_state <= RX_IDLE;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            if (!rx_in) begin
              rx_state <= RX_START; // see (RULE8)
              rx_os    <= 4'h0;
              rx_fer   <= 1'b0;
            end
          end
          RX_START: begin
            if (os_tick && rx_os == OS_MID) begin
              rx_os <= 4'h0;
              if (!rx_in) begin
                rx_state <= RX_DATA; // see (RULE24)
                rx_bits  <= dbits - 4'h1;
              end else begin
                rx_state <= RX_IDLE;
              end
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_shift <= {rx_in, rx_shift[8:1]};
              if (rx_bits != 4'h0) begin
                rx_bits <= rx_bits - 4'h1;
              end else if (mode[MODE_PAR_EN]) begin
                rx_state <= RX_PARITY;
              end else begin
                rx_state <= RX_STOP;
                rx_per   <= 1'b0;
                rx_bits  <= {3'h0, mode[MODE_STOP2]};
              end
            end
          end
          RX_PARITY: begin
            if (rx_sample) begin
              rx_per   <= (^rx_wire) ^ rx_in ^ mode[MODE_ODD]; // see (RULE15)
              rx_state <= RX_STOP;
              rx_bits  <= {3'h0, mode[MODE_STOP2]};
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              if (!rx_in)
                rx_fer <= 1'b1;
              if (rx_bits != 4'h0)
                rx_bits <= rx_bits - 4'h1;
              else
                rx_state <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Receive buffer; a new character wins over a read in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxbuf      <= 9'h000;
      rx_full    <= 1'b0;
      rx_request <= 1'b0;
    end else if (ce) begin
      rx_request <= rx_accept && !rx_full; // see (RULE11) (RULE13)
      if (rx_accept) begin
        rxbuf   <= (rx_wire ^ {9{data_inv}}) & dmask; // see (RULE13) (RULE18)
        rx_full <= 1'b1;
      end else if (rx_read) begin
        rx_full <= 1'b0;
      end
    end
  end

  // The last stop bit is checked at its mid-point, so rx_fer is not final yet
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovr <= 1'b0;
      fer <= 1'b0;
      per <= 1'b0;
    end else if (ce) begin
      if (!rx_en) begin
        ovr <= 1'b0; // see (RULE25)
        fer <= 1'b0;
        per <= 1'b0;
      end else if (rx_accept) begin
        ovr <= rx_full; // see (RULE12)
        fer <= rx_fer | ~rx_in; // see (RULE14)
        per <= rx_per & mode[MODE_PAR_EN];
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (ce && rd) begin
      unique case (addr)
        REG_MODE:   rdata <= mode;
        REG_CTRL:   rdata <= ctrl;
        REG_DIV:    rdata <= {8'h00, div_n};
        REG_TXBUF:  rdata <= {7'h00, txbuf};
        REG_RXBUF:  rdata <= {ovr | fer | per, per, fer, ovr, 3'h0, rxbuf};
        REG_STATUS: rdata <= {9'h000, ovr | fer | per, per, fer, ovr, rx_full,
                              tx_state == TX_IDLE, tbe}; // see (RULE16)
        default:    rdata <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  tx_start_gate_a: assert property (ce && tx_state == TX_IDLE ##1 tx_state == TX_START |-> // see (RULE7)
    $past(tx_en) && $past(cts_ok) && $past(!tbe)) else $error("transmit started without its conditions");
  tx_idle_level_a: assert property (ce && tx_state == TX_IDLE |=> serial_out_pin != $past(pin_inv)) // see (RULE23)
    else $error("idle transmit pin not at rest level");
  tx_load_req_a: assert property (ce && tx_start && !ctrl[CTRL_TX_WHEN] |=> tx_request) // see (RULE9)
    else $error("no transmit request on buffer load");
  tx_done_req_a: assert property (ce && tx_start && ctrl[CTRL_TX_WHEN] |=> !tx_request) // see (RULE10)
    else $error("transmit request before frame end");
  tx_end_req_a: assert property (ce && tx_done && ctrl[CTRL_TX_WHEN] |=> tx_request) // see (RULE10)
    else $error("no transmit request at frame end");
  rx_start_mid_a: assert property (rx_state == RX_START ##1 rx_state == RX_DATA |-> $past(!rx_in)) // see (RULE24)
    else $error("start bit not low at mid-bit");
  rx_req_fresh_a: assert property (ce && rx_accept && !rx_full |=> rx_request && rx_full) // see (RULE11)
    else $error("receive request missing");
  overrun_flag_a: assert property (ce && rx_accept && rx_full && rx_en |=> ovr && !rx_request) // see (RULE12) (RULE13)
    else $error("overrun not flagged or request raised");
  sleep_drop_a: assert property (ce && rx_done && sleep_on && !rx_msb |=> !rx_request && $stable(rxbuf)) // see (RULE22)
    else $error("sleep mode kept a zero-msb character");
  err_sum_read_a: assert property (ce && rd && addr == REG_STATUS |=> // see (RULE16)
    rdata[STAT_SUM] == (rdata[STAT_OVR] | rdata[STAT_FER] | rdata[STAT_PER])) else $error("error sum wrong");
  err_clear_a: assert property (ce && !rx_en |=> !ovr && !fer && !per) // see (RULE25)
    else $error("errors not cleared with receiver off");

  frame_sent_c: cover property (tx_done && ce);
  char_taken_c: cover property (rx_accept && ce && !rx_full);
  overrun_c:    cover property (rx_accept && ce && rx_full);
  framing_c:    cover property (ce && rx_accept ##1 fer);
endmodule // async_serial_channel

//--- hw/serial_pkg.sv
// Overview of operation
// (RULE1) Characters carry 7, 8 or 9 data bits, chosen by software.
// (RULE2) One start bit opens each frame; parity is odd, even or absent.
// (RULE3) One or two stop bits close each frame, as configured.
// (RULE4) Internal clock: bit rate is selected clock over 16 times (divider plus one).
// (RULE5) Divider takes 8-bit values 00 to ff, dividing by 1 to 256.
// (RULE6) External clock: bit rate is transfer clock pin over 16(n+1).
// (RULE7) Transmit starts only with enable set, buffer full and clear-to-send low if used.
// (RULE8) Receive starts only with receive enable set and a start bit seen.
// (RULE9) Cause select clear: transmit request when buffer moves into shift register.
// (RULE10) Cause select set: transmit request when the whole frame has left.
// (RULE11) Receive request when a character moves into the receive buffer.
// (RULE12) Overrun flags when a character completes before the previous one was read.
// (RULE13) On overrun the buffer is overwritten and no receive request is raised.
// (RULE14) Framing error when a configured stop bit is not found high.
// (RULE15) Parity error when ones in data and parity disagree with setting.
// (RULE16) Error sum reads one while any overrun, framing or parity error stands.
// (RULE17) First two channels offer sleep mode for multiprocessor addressing.
// (RULE18) Third channel may invert data bits only, not start, parity or stop.
// (RULE19) Third channel may invert the transmit and receive pin levels entirely.
// (RULE20) Third channel ignores the external clock select; internal clock only.
// (RULE21) Software sets flow control disable on the third channel.
// (RULE22) Sleep mode keeps only characters whose most significant data bit is one.
// (RULE23) Transmit pin idles high, or floats when open drain is chosen.
// (RULE24) Start bit falling edge found on 16x clock, confirmed low at mid-bit; the receiver here leaves idle on any clock with the line low.
// (RULE25) Error flags latch per character and clear while reception is disabled.
package serial_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] REG_MODE   = 3'h0;
  localparam logic [2:0] REG_CTRL   = 3'h1;
  localparam logic [2:0] REG_DIV    = 3'h2;
  localparam logic [2:0] REG_TXBUF  = 3'h3;
  localparam logic [2:0] REG_RXBUF  = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam int MODE_LEN     = 0;
  localparam int MODE_EXT     = 3;
  localparam int MODE_STOP2   = 4;
  localparam int MODE_ODD     = 5;
  localparam int MODE_PAR_EN  = 6;
  localparam int MODE_SLEEP   = 7;
  localparam int MODE_OPEN_DR = 8;
  localparam int CTRL_TX_EN   = 0;
  localparam int CTRL_TX_WHEN = 1;
  localparam int CTRL_RX_EN   = 2;
  localparam int CTRL_FLOW_DIS = 3;
  localparam int CTRL_RTS_SEL = 4;
  localparam int CTRL_DATA_INV = 5;
  localparam int CTRL_PIN_INV = 6;
  localparam int CTRL_CLK_SEL = 8;
  localparam int STAT_TBE     = 0;
  localparam int STAT_TX_IDLE = 1;
  localparam int STAT_RX_FULL = 2;
  localparam int STAT_OVR     = 3;
  localparam int STAT_FER     = 4;
  localparam int STAT_PER     = 5;
  localparam int STAT_SUM     = 6;
  localparam int RXBUF_ERR    = 12;
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_9 = 2'h2;
  localparam logic [1:0] CLK_F1 = 2'h0;
  localparam logic [1:0] CLK_F8 = 2'h1;
  localparam logic [1:0] CLK_F32 = 2'h2;
  localparam logic [15:0] MODE_RESET = 16'h0001;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0]  DIV_RESET  = 8'h00;
  localparam logic [2:0] PRE_F8_LAST  = 3'h7;
  localparam logic [4:0] PRE_F32_LAST = 5'h1f;
  localparam logic [3:0] OS_LAST  = 4'hf;
  localparam logic [3:0] OS_MID   = 4'h7;
  localparam logic [3:0] MAX_BITS = 4'h9;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

//--- dv/remote_node.sv
`timescale 1ns/1ps
module remote_node (
  input  wire logic        clk,
  input  wire logic        from_dut,
  output logic             to_dut,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  data_bits,
  input  wire logic        two_stops,
  output logic [8:0]       got_data,
  output logic             got_ok,
  output logic [7:0]       got_count
);
  int i;
  // Caller enters right after a rising edge; each level holds n edges
  task automatic send_bit(input logic v, input logic [15:0] n);
    to_dut <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic send(input logic [8:0] d, input logic [3:0] nb, input logic [15:0] n, input logic pe,
                      input logic p, input logic [1:0] stops, input logic lvl);
    send_bit(1'b0, n);
    for (int k = 0; k < nb; k++) send_bit(d[k], n);
    if (pe) send_bit(p, n);
    repeat (stops) send_bit(lvl, n);
    // Idle bit returns a low stop to rest and keeps back-to-back frames apart
    send_bit(1'b1, n);
  endtask
  // Mid-bit sampling of the frames that the channel sends
  initial begin
    to_dut = 1'b1;
    got_count = '0;
    got_data = '0;
    got_ok = 1'b0;
    forever begin
      @(negedge from_dut);
      got_data = '0;
      repeat (bit_clks / 2) @(posedge clk);
      got_ok = !from_dut;
      for (i = 0; i < data_bits; i++) begin
        repeat (bit_clks) @(posedge clk);
        got_data[i] = from_dut;
      end
      repeat (two_stops ? 2 : 1) begin
        repeat (bit_clks) @(posedge clk);
        got_ok &= from_dut;
      end
      got_count++;
    end
  end
endmodule // remote_node

//--- dv/test_async_serial_channel.sv
`timescale 1ns/1ps
module test_async_serial_channel;
  import serial_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              serial_in_pin;
  logic              serial_out_pin;
  logic              flow_pin_in = 1'b1;
  logic [15:0]       bit_clks = 16'h0010;
  logic [3:0]        data_bits = 4'h8;
  logic              two_stops = 1'b0;
  logic [8:0]        got_data;
  logic              got_ok;
  logic [7:0]        got_count;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                n_tx = 0;
  int                n_rx = 0;
  int                t;
  logic              tx_request;
  logic              rx_request;
  logic              serial_out_oe;
  logic              flow_pin_out;
  logic              flow_pin_oe;
  logic [1:0]        xdiv = 2'h0;

  async_serial_channel async_serial_channel_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_in_pin(serial_in_pin),
    .transfer_clock_pin(xdiv[1]), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .flow_pin_in(flow_pin_in), .flow_pin_out(flow_pin_out), .flow_pin_oe(flow_pin_oe), .tx_request(tx_request),
    .rx_request(rx_request));
  remote_node remote_node_inst (.clk(clk), .from_dut(serial_out_pin), .to_dut(serial_in_pin),
    .bit_clks(bit_clks), .data_bits(data_bits), .two_stops(two_stops), .got_data(got_data),
    .got_ok(got_ok), .got_count(got_count));

  always #2.5 clk = ~clk;
  // External bit clock: each level lasts two clocks so the pin filter passes it
  always @(posedge clk) xdiv <= xdiv + 2'h1;
  always @(posedge clk) begin
    if (tx_request === 1'b1) n_tx++;
    if (rx_request === 1'b1) n_rx++;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Bounded wait for the far end to finish decoding a frame
  task automatic wait_got(input int lim);
    logic [7:0] old;
    old = got_count;
    repeat (lim) if (got_count == old) @(posedge clk);
    chk(16'(got_count - old), 16'h0001);
    // Let the stop bit run out before anything is reconfigured
    repeat (bit_clks / 2 + 16'h0008) @(posedge clk);
  endtask
  task automatic rx_case(input logic [15:0] m, input logic [8:0] d, input logic [3:0] nb, input logic pe,
                         input logic p, input logic [1:0] st, input logic lvl, input logic [15:0] e, input int q);
    int r;
    wr_reg(REG_MODE, m);
    r = n_rx;
    @(posedge clk);
    remote_node_inst.send(d, nb, 16'h0020, pe, p, st, lvl);
    repeat (3) @(posedge clk);
    chk(16'(n_rx - r), 16'(q));
    if (q != 0) rd_chk(REG_RXBUF, e);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({14'h0000, serial_out_pin, serial_out_oe}, 16'h0003);
    rd_chk(REG_MODE, MODE_RESET);
    rd_chk(REG_CTRL, CTRL_RESET);
    rd_chk(REG_DIV, {8'h00, DIV_RESET});
    rd_chk(REG_STATUS, 16'h0003);
    wr_reg(3'h7, 16'hffff);
    rd_chk(3'h7, 16'h0000);
    wr_reg(REG_CTRL, 16'h000d);
    t = n_tx;
    wr_reg(REG_TXBUF, 16'h005a);
    repeat (4) @(posedge clk);
    chk(16'(n_tx - t), 16'h0001);
    wait_got(300);
    chk({7'h00, got_data}, 16'h005a);
    // Slow f8 source and frame-end cause, 7 bits with two stops
    bit_clks <= 16'h0080;
    data_bits <= 4'h7;
    two_stops <= 1'b1;
    wr_reg(REG_MODE, 16'h0010);
    wr_reg(REG_CTRL, 16'h010f);
    t = n_tx;
    wr_reg(REG_TXBUF, 16'h0055);
    repeat (20) @(posedge clk);
    chk(16'(n_tx - t), 16'h0000);
    wait_got(2000);
    chk({7'h00, got_data}, 16'h0055);
    chk(16'(got_ok), 16'h0001);
    repeat (100) @(posedge clk);
    chk(16'(n_tx - t), 16'h0001);
    // Clear-to-send held high blocks the start
    bit_clks <= 16'h0010;
    data_bits <= 4'h8;
    two_stops <= 1'b0;
    wr_reg(REG_MODE, 16'h0001);
    wr_reg(REG_CTRL, 16'h0005);
    wr_reg(REG_TXBUF, 16'h00c3);
    repeat (300) @(posedge clk);
    chk(16'(serial_out_pin), 16'h0001);
    flow_pin_in <= 1'b0;
    wait_got(400);
    chk({7'h00, got_data}, 16'h00c3);
    // Receive side at divider 1, thirty-two clocks per bit
    wr_reg(REG_DIV, 16'h0001);
    wr_reg(REG_CTRL, 16'h0009);
    rx_case(16'h0001, 9'h011, 4'h8, 1'b0, 1'b0, 2'h1, 1'b1, 16'h0000, 0);
    wr_reg(REG_CTRL, 16'h000d);
    rx_case(16'h0001, 9'h0a5, 4'h8, 1'b0, 1'b0, 2'h1, 1'b1, 16'h00a5, 1);
    t = n_rx;
    @(posedge clk);
    remote_node_inst.send(9'h011, 4'h8, 16'h0020, 1'b0, 1'b0, 2'h1, 1'b1);
    remote_node_inst.send(9'h022, 4'h8, 16'h0020, 1'b0, 1'b0, 2'h1, 1'b1);
    repeat (3) @(posedge clk);
    chk(16'(n_rx - t), 16'h0001);
    rd_chk(REG_RXBUF, 16'h9022);
    rx_case(16'h0002, 9'h1a5, 4'h9, 1'b0, 1'b0, 2'h1, 1'b1, 16'h01a5, 1);
    rx_case(16'h0000, 9'h05a, 4'h7, 1'b0, 1'b0, 2'h1, 1'b1, 16'h005a, 1);
    rx_case(16'h0041, 9'h035, 4'h8, 1'b1, 1'b0, 2'h1, 1'b1, 16'h0035, 1);
    rx_case(16'h0041, 9'h035, 4'h8, 1'b1, 1'b1, 2'h1, 1'b1, 16'hc035, 1);
    rx_case(16'h0061, 9'h035, 4'h8, 1'b1, 1'b1, 2'h1, 1'b1, 16'h0035, 1);
    rx_case(16'h0011, 9'h03c, 4'h8, 1'b0, 1'b0, 2'h2, 1'b1, 16'h003c, 1);
    rx_case(16'h0081, 9'h012, 4'h8, 1'b0, 1'b0, 2'h1, 1'b1, 16'h0000, 0);
    rx_case(16'h0081, 9'h092, 4'h8, 1'b0, 1'b0, 2'h1, 1'b1, 16'h0092, 1);
    rx_case(16'h0001, 9'h03c, 4'h8, 1'b0, 1'b0, 2'h1, 1'b0, 16'ha03c, 1);
    wr_reg(REG_CTRL, 16'h0009);
    rd_chk(REG_STATUS, 16'h0003);
    // External bit clock rises every four clocks; divider 1 gives 128 clocks per bit
    bit_clks <= 16'h0080;
    wr_reg(REG_MODE, 16'h0009);
    wr_reg(REG_TXBUF, 16'h001e);
    wait_got(2000);
    chk({7'h00, got_data}, 16'h001e);
    // Open drain floats the idle line; request-to-send drives low while there is room
    wr_reg(REG_MODE, 16'h0101);
    wr_reg(REG_CTRL, 16'h0014);
    repeat (2) @(posedge clk);
    chk({13'h0000, serial_out_oe, flow_pin_oe, flow_pin_out}, 16'h0002);
    print_verdict;
  end
endmodule // test_async_serial_channel
